/* File: hdl/deser_out_pkg.sv */
// Purpose: shared constants for the deserializer output control
// Assumes: 40 MHz core_clk, AXI4-Lite register access
// Notes: byte offsets of the register map
package deser_out_pkg;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] irq_stat_off = 8'h08;
  localparam logic [7:0] irq_mask_off = 8'h0c;
  localparam logic [7:0] mod_div_off = 8'h10;
  // ctrl fields
  localparam int ctrl_spread_bit = 0;
  localparam int ctrl_edge_bit = 1;
  localparam int ctrl_band_lo = 2;
  localparam int ctrl_en_bit = 4;
  localparam logic [31:0] ctrl_reset = 32'h0000_0012;
  // irq bits
  localparam int irq_spread_bit = 0;
  localparam int irq_settled_bit = 1;
  localparam int irq_lost_bit = 2;
  localparam logic [2:0] irq_mask_reset = 3'h0;
  // timing
  localparam int clk_mhz = 40;
  localparam int spread_settle_periods = 32000;
  localparam int mod_divide = 1024;
  localparam int bus_handover_ns = 30;
  localparam int bus_handover_cycles = (bus_handover_ns * clk_mhz + 999) / 1000;
  localparam int serializer_settle_periods = 17100;
  localparam int sync_stages = 2;
  localparam int stagger_cycles = 1;
  localparam int video_bits = 18;
  localparam int control_bits = 9;
  localparam int group_bits = 6;
  typedef enum logic [1:0] {
    st_sleep = 2'b00,
    st_ref = 2'b01,
    st_settle = 2'b10,
    st_live = 2'b11
  } out_state_e;
endpackage

/* File: hdl/video_deser_output_control.sv */
// Purpose: output side control of a video link deserializer
// Assumes: recovered word stream and serial activity come from the core; lock is made here
// Notes: one clock, synchronous active-high reset
`timescale 1ns/1ps
module video_deser_output_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_n,
  input wire logic output_drive_enable,
  input wire logic serial_active,
  input wire logic word_valid,
  input wire logic word_is_video,
  input wire logic [17:0] recovered_word,
  input wire logic local_reference_clock,
  input wire logic recovered_clock,
  output logic [17:0] video_word_out,
  output logic [17:0] video_word_oe,
  output logic [8:0] control_word_out,
  output logic [8:0] control_word_oe,
  output logic video_phase_flag,
  output logic pclk_out,
  output logic pclk_oe,
  output logic capture_on_rising,
  output logic spread_wide,
  output logic mod_tick,
  output logic slow_edges,
  output logic [1:0] band_out,
  output logic lock_n,
  output logic lock_oe,
  output logic data_valid,
  output logic irq
);

  // ------------------------------------------------
  // register bus
  // ------------------------------------------------
  logic [31:0] ctrl;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [2:0] irq_event;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = do_write && aw_addr == deser_out_pkg::ctrl_off;
  wire wr_stat = do_write && aw_addr == deser_out_pkg::irq_stat_off;
  wire wr_mask = do_write && aw_addr == deser_out_pkg::irq_mask_off;
  wire wr_known = wr_ctrl || wr_stat || wr_mask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  wire [31:0] next_ctrl = merge(ctrl, w_data, w_strb);
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl <= deser_out_pkg::ctrl_reset;
      irq_mask <= deser_out_pkg::irq_mask_reset;
      irq_stat <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= next_ctrl & 32'h0000_001f;
      if (wr_mask && w_strb[0])
        irq_mask <= w_data[2:0];
      // set wins over clear
      irq_stat <= (irq_stat & ~((wr_stat && w_strb[0]) ? w_data[2:0] : 3'h0)) | irq_event;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // ------------------------------------------------
  // select synchronisers
  // ------------------------------------------------
  logic [4:0] sel_meta;
  logic [4:0] sel_sync;
  logic [4:0] sel_last;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sel_meta <= 5'h00;
      sel_sync <= 5'h00;
      sel_last <= 5'h00;
    end
    else
    begin
      sel_meta <= ctrl[4:0];
      sel_sync <= sel_meta;
      sel_last <= sel_sync;
    end
  end
  wire spread_sel = sel_sync[deser_out_pkg::ctrl_spread_bit];
  wire edge_sel = sel_sync[deser_out_pkg::ctrl_edge_bit];
  wire [1:0] band_sel = sel_sync[deser_out_pkg::ctrl_band_lo +: 2];
  wire spread_change = sel_sync[0] != sel_last[0];
  assign spread_wide = spread_sel;
  assign capture_on_rising = edge_sel;
  assign band_out = band_sel;
  assign slow_edges = !band_sel[1];

  // ------------------------------------------------
  // modulation rate
  // ------------------------------------------------
  logic [9:0] mod_cnt;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      mod_cnt <= 10'h000;
    else
      mod_cnt <= mod_cnt + 10'h001;
  end
  assign mod_tick = mod_cnt == 10'(deser_out_pkg::mod_divide - 1);

  // ------------------------------------------------
  // output state
  // ------------------------------------------------
  deser_out_pkg::out_state_e state;
  deser_out_pkg::out_state_e next_state;
  logic [15:0] settle_cnt;
  wire settle_done = settle_cnt == 16'(deser_out_pkg::spread_settle_periods - 1);

  always_comb
  begin
    next_state = state;
    unique case (state)
      deser_out_pkg::st_sleep: if (sleep_n) next_state = deser_out_pkg::st_ref;
      deser_out_pkg::st_ref: if (serial_active) next_state = deser_out_pkg::st_live;
      deser_out_pkg::st_settle: if (settle_done) next_state = deser_out_pkg::st_live;
      deser_out_pkg::st_live: if (spread_change) next_state = deser_out_pkg::st_settle;
    endcase
    if (state != deser_out_pkg::st_sleep && !serial_active)
      next_state = deser_out_pkg::st_ref;
    if (state == deser_out_pkg::st_settle && spread_change)
      next_state = deser_out_pkg::st_settle;
    if (!sleep_n)
      next_state = deser_out_pkg::st_sleep;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= deser_out_pkg::st_sleep;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      settle_cnt <= (next_state == deser_out_pkg::st_settle && !spread_change
                     && state == deser_out_pkg::st_settle) ? settle_cnt + 16'h0001 : 16'h0000;
    end
  end

  wire live = state == deser_out_pkg::st_live;
  wire awake = state != deser_out_pkg::st_sleep;
  assign irq_event = {awake && !serial_active, live && state != next_state ? 1'b0 :
                      (state == deser_out_pkg::st_settle && next_state == deser_out_pkg::st_live),
                      spread_change};
  assign data_valid = live;

  // ------------------------------------------------
  // data path
  // ------------------------------------------------
  logic [17:0] video_hold;
  logic [17:0] video_lag1;
  logic [17:0] video_lag2;
  logic [8:0] control_hold;
  logic phase_hold;
  wire take = live && word_valid;
  always_ff @(posedge core_clk)
  begin
    if (rst || !live)
    begin
      video_hold <= 18'h00000;
      control_hold <= 9'h000;
      phase_hold <= 1'b0;
      video_lag1 <= 18'h00000;
      video_lag2 <= 18'h00000;
    end
    else
    begin
      if (take && word_is_video)
        video_hold <= recovered_word;
      if (take && !word_is_video)
        control_hold <= recovered_word[8:0];
      if (take)
        phase_hold <= word_is_video;
      video_lag1 <= video_hold;
      video_lag2 <= video_lag1;
    end
  end
  assign video_word_out = {video_lag2[17:12], video_lag1[11:6], video_hold[5:0]};
  assign control_word_out = control_hold;
  assign video_phase_flag = phase_hold;
  assign pclk_out = (live ? recovered_clock : local_reference_clock) ^ ~edge_sel;

  // ------------------------------------------------
  // pin enables
  // ------------------------------------------------
  wire drive = awake && output_drive_enable;
  assign video_word_oe = {18{drive}};
  assign control_word_oe = {9{drive}};
  assign pclk_oe = drive;
  assign lock_oe = awake;
  assign lock_n = !live;

  // ------------------------------------------------
  // register read
  // ------------------------------------------------
  wire rd_ctrl = s_axi_araddr == deser_out_pkg::ctrl_off;
  wire rd_status = s_axi_araddr == deser_out_pkg::status_off;
  wire rd_stat = s_axi_araddr == deser_out_pkg::irq_stat_off;
  wire rd_mask = s_axi_araddr == deser_out_pkg::irq_mask_off;
  wire rd_div = s_axi_araddr == deser_out_pkg::mod_div_off;
  wire rd_known = rd_ctrl || rd_status || rd_stat || rd_mask || rd_div;
  wire [31:0] status_word = {29'h0, live, awake, serial_active};
  wire [31:0] read_word = ({32{rd_ctrl}} & ctrl) | ({32{rd_status}} & status_word)
    | ({32{rd_stat}} & {29'h0, irq_stat}) | ({32{rd_mask}} & {29'h0, irq_mask})
    | ({32{rd_div}} & 32'(deser_out_pkg::mod_divide));
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  property p_spread_blank;
    @(posedge core_clk) disable iff (rst) spread_change && live |=> !data_valid;
  endproperty
  a_spread_blank: assert property (p_spread_blank) else $error("valid after spread change");
  property p_blank_low;
    @(posedge core_clk) disable iff (rst) !live
      |=> control_word_out == 9'h000 && video_word_out == 18'h00000;
  endproperty
  a_blank_low: assert property (p_blank_low) else $error("outputs not low when invalid");
  property p_oe;
    @(posedge core_clk) disable iff (rst) !output_drive_enable |-> !pclk_oe && lock_oe == awake;
  endproperty
  a_oe: assert property (p_oe) else $error("enable misapplied");
  property p_hold;
    @(posedge core_clk) disable iff (rst) live && !(take && !word_is_video) ##1 live
      |-> $stable(control_word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed outside phase");
  property p_stagger;
    @(posedge core_clk) disable iff (rst) live ##1 live ##1 live
      |-> video_word_out[17:12] == $past(video_hold[17:12], 2)
      && video_word_out[11:6] == $past(video_hold[11:6]);
  endproperty
  a_stagger: assert property (p_stagger) else $error("stagger wrong");
  property p_phase;
    @(posedge core_clk) disable iff (rst) take |=> video_phase_flag == $past(word_is_video);
  endproperty
  a_phase: assert property (p_phase) else $error("phase flag wrong");
  property p_mod;
    @(posedge core_clk) disable iff (rst) mod_tick |=> !mod_tick;
  endproperty
  a_mod: assert property (p_mod) else $error("modulation tick too fast");
  property p_sleep;
    @(posedge core_clk) disable iff (rst) !sleep_n |=> !lock_oe && video_word_oe == 18'h00000;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not tristated");
endmodule

/* File: test/display_latch_model.sv */
// Purpose: downstream chip latching the parallel video outputs
// Assumes: a pull-down on every output line
// Notes: capture edge follows the edge select output
`timescale 1ns/1ps
module display_latch_model (
  input wire logic pclk_out,
  input wire logic pclk_oe,
  input wire logic capture_on_rising,
  input wire logic [17:0] video_word_out,
  input wire logic [17:0] video_word_oe,
  output logic [17:0] seen_video
);
  logic clk_line;
  logic [17:0] data_line;
  // released lines fall to the pull-down level
  assign clk_line = pclk_oe & pclk_out;
  assign data_line = video_word_out & video_word_oe;
  initial seen_video = 18'h0;
  always @(posedge clk_line) if (capture_on_rising) seen_video <= data_line;
  always @(negedge clk_line) if (!capture_on_rising) seen_video <= data_line;
endmodule

/* File: test/testbench.sv */
// Purpose: self-checking bench for the deserializer output control
// Assumes: 40 MHz core_clk, AXI4-Lite reads and writes
// Notes: settle counts run at full length
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0, rst = 1'b1, sleep_n = 1'b0, output_drive_enable = 1'b1;
  logic serial_active = 1'b0, word_valid = 1'b0, word_is_video = 1'b0, strb = 1'b0;
  logic local_reference_clock = 1'b0, recovered_clock = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, meas = 32'h0, tick_gap = 32'h0, tick_cnt = 32'h0;
  logic [31:0] seed = 32'h000042bb; // xorshift start value
  logic [31:0] obs, exp_v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [17:0] recovered_word = 18'h0, w1, w3, video_word_out, video_word_oe, seen_video;
  logic [8:0] w2, control_word_out, control_word_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp, band_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic video_phase_flag, pclk_out, pclk_oe, capture_on_rising, spread_wide, mod_tick;
  logic slow_edges, lock_n, lock_oe, data_valid, irq;
  logic [31:0] s_axi_rdata;
  logic [2:0] sel = 3'h0;
  logic [31:0] q[$];
  logic [1:0] bq[$];
  logic [31:0] rq[$];
  logic [1:0] rrq[$];
  int err_count = 0, n_tests = 0, n;

  video_deser_output_control u_video_deser_output_control (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sleep_n, .output_drive_enable, .serial_active, .word_valid,
    .word_is_video, .recovered_word, .local_reference_clock, .recovered_clock,
    .video_word_out, .video_word_oe, .control_word_out, .control_word_oe, .video_phase_flag,
    .pclk_out, .pclk_oe, .capture_on_rising, .spread_wide, .mod_tick, .slow_edges,
    .band_out, .lock_n, .lock_oe, .data_valid, .irq);
  display_latch_model u_display_latch_model (.pclk_out, .pclk_oe, .capture_on_rising,
    .video_word_out, .video_word_oe, .seen_video);

  // ------------------------------
  // clocks and observation
  // ------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    recovered_clock <= ~recovered_clock;
    local_reference_clock <= recovered_clock;
    tick_cnt <= mod_tick ? 32'h0 : tick_cnt + 32'h1;
    if (mod_tick) tick_gap <= tick_cnt + 32'h1;
  end
  always_comb
    case (sel)
      3'h0: obs = {14'h0, video_word_out};
      3'h1: obs = {23'h0, control_word_out};
      3'h2: obs = {26'h0, spread_wide, capture_on_rising, slow_edges, band_out, irq};
      3'h3: obs = {25'h0, video_phase_flag, data_valid, lock_n, lock_oe, pclk_oe,
        |video_word_oe, |control_word_oe};
      3'h4: obs = {14'h0, seen_video};
      3'h5: obs = tick_gap;
      default: obs = meas;
    endcase
  task automatic rpt(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge core_clk)
  begin
    if (strb) rpt(obs, q.pop_front());
    if (s_axi_bvalid && s_axi_bready) rpt({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) rpt(s_axi_rdata, rq.pop_front());
    if (s_axi_rvalid && s_axi_rready) rpt({30'h0, s_axi_rresp}, {30'h0, rrq.pop_front()});
  end

  // ------------------------------
  // drivers
  // ------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [2:0] s, input logic [31:0] e);
    q.push_back(e);
    sel <= s;
    strb <= 1'b1;
    @(posedge core_clk);
    strb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    rq.push_back(e);
    rrq.push_back(r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic word(input logic v, input logic [17:0] w);
    word_is_video <= v;
    recovered_word <= w;
    word_valid <= 1'b1;
    @(posedge core_clk);
    word_valid <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic wait_live(input int lim);
    n = 0;
    while (data_valid !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(3'h3, 32'h10);
    chk(3'h2, 32'h18);
    serial_active <= 1'b1;
    repeat (deser_out_pkg::serializer_settle_periods) @(posedge core_clk);
    sleep_n <= 1'b1;
    wait_live(40000);
    chk(3'h3, 32'h2f);
    for (int b = 0; b < 4; b++)
    begin
      seed = xs(seed);
      wr(deser_out_pkg::ctrl_off, {28'h0, b[1:0], seed[0], 1'b0}, 2'b00);
      repeat (4) @(posedge core_clk);
      chk(3'h2, {26'h0, 1'b0, seed[0], ~b[1], b[1:0], 1'b0});
    end
    rd(deser_out_pkg::ctrl_off, {28'h0, 2'b11, seed[0], 1'b0}, 2'b00);
    rd(deser_out_pkg::status_off, 32'h7, 2'b00);
    wr(8'h20, 32'h1, 2'b10);
    rd(8'h20, 32'h0, 2'b10);
    seed = xs(seed);
    w1 = seed[17:0];
    w2 = seed[26:18];
    w3 = ~seed[17:0];
    word(1'b1, w1);
    chk(3'h0, {14'h0, w1});
    chk(3'h3, 32'h6f);
    word(1'b0, {9'h0, w2});
    chk(3'h1, {23'h0, w2});
    chk(3'h0, {14'h0, w1});
    chk(3'h3, 32'h2f);
    word(1'b1, w3);
    chk(3'h1, {23'h0, w2});
    repeat (8) @(posedge core_clk);
    chk(3'h4, {14'h0, w3});
    output_drive_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(3'h3, 32'h68);
    repeat (deser_out_pkg::bus_handover_cycles + 1) @(posedge core_clk);
    output_drive_enable <= 1'b1;
    repeat (2100) @(posedge core_clk);
    chk(3'h5, 32'h00000400);
    rd(deser_out_pkg::mod_div_off, 32'h00000400, 2'b00);
    wr(deser_out_pkg::irq_mask_off, 32'h1, 2'b00);
    wr(deser_out_pkg::ctrl_off, 32'h0000000b, 2'b00);
    repeat (6) @(posedge core_clk);
    chk(3'h0, 32'h0);
    chk(3'h2, 32'h35);
    wait_live(34000);
    meas <= {31'h0, n >= deser_out_pkg::spread_settle_periods - 64 && n < 34000};
    chk(3'h6, 32'h1);
    rd(deser_out_pkg::irq_stat_off, 32'h3, 2'b00);
    wr(deser_out_pkg::irq_stat_off, 32'h1, 2'b00);
    chk(3'h2, 32'h34);
    wr(deser_out_pkg::irq_mask_off, 32'h2, 2'b00);
    chk(3'h2, 32'h35);
    wr(deser_out_pkg::irq_stat_off, 32'h2, 2'b00);
    chk(3'h2, 32'h34);
    serial_active <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(3'h0, 32'h0);
    chk(3'h3, 32'h1f);
    rd(deser_out_pkg::status_off, 32'h2, 2'b00);
    rd(deser_out_pkg::irq_stat_off, 32'h4, 2'b00);
    end_sim();
  end
  initial
  begin
    #1500000;
    err_count++;
    end_sim();
  end
endmodule
